/* hw/pmbc_map.vh */
// Purpose: Constants for the processor memory bus controller.
// Assumes: 125 MHz CLOCK; all inputs synchronous to it.
// Notes: Included by both design files.
// How it works
// R01 - Status read drives X bus 13..15
// R02 - Halt only at cycle 2/3 boundary
// R03 - Idle flag when no reference; gates halt
// R04 - Read enable at end of cycle 2
// R05 - Low load captures both address registers
// R06 - High load captures address bits 17..23
// R07 - One address source drives the bus
// R08 - Write data captured from Y bus
// R09 - Write data drives bus only when enabled
// R10 - Address 18,17 picks counter or control (code has no control register; select 3 writes nothing)
// R11 - Gate starts count, first tick loads
// R12 - Counter 2 clocked by counter 1 carry
// R13 - Primary timer tick every 16 ms
// R14 - Timer strobes ignored without select
// R15 - Counter 0 output is timer interrupt
// R16 - Select when 23,21,20 read 1,0,0
// R17 - Address patterns clear/set timer gates (code has no clear pattern for COUNTER12_GATE; only reset clears it)
// R18 - Three resets merge into synchronised reset
// R19 - Initial trap after boot completes
// R20 - Memory request for memory or map reference
// R21 - Memory controller raises ready when done
// R22 - Interrupt set when enabled, cleared by strobe
// R23 - Clock enable in second halves, none when stopped
// R24 - Cycle 1 first half loads high, latch enable
// R25 - Read cycle 3 waits for ready
// R26 - Resume at cycle 3 after halt
// R27 - Reset clears gates, interrupt; idle asserted
`ifndef PMBC_MAP_VH
`define PMBC_MAP_VH
`define PMBC_CLK_MHZ        125
`define PMBC_TICK_MS        16
`define PMBC_TICK_CYCLES    (`PMBC_TICK_MS * 1000 * `PMBC_CLK_MHZ)
`define PMBC_A_LOW_W        16
`define PMBC_A_HIGH_W       7
`define PMBC_A_SEL1         18
`define PMBC_A_SEL0         17
`define PMBC_CNT_W          16
`define PMBC_SEL_CTRL       2'h3
`define PMBC_DEC_CS         3'h4
`define PMBC_DEC_CLR0       4'hA
`define PMBC_DEC_SET0       4'hB
`define PMBC_DEC_SET12      4'hD
`define PMBC_ZERO16         16'h0000
`endif

/* hw/pmbc_timer.v */
// Purpose: Three-counter interval timer with gate-triggered reload.
// Assumes: Strobes and selects sampled on CLOCK.
// Notes: Counters 0 and 1 count down at ticks, counter 2 at counter 1 carries; reload on first such clock after gate rises.
`timescale 1ns/100ps
`default_nettype none
`include "pmbc_map.vh"
module pmbc_timer (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // Host access
    input  wire        timer_select_n,
    input  wire        io_write_n,
    input  wire [1:0]  sel,
    input  wire [15:0] wdata,
    // Timing
    input  wire        tick,
    input  wire        counter0_gate,
    input  wire        counter12_gate,
    // Results
    output wire        timer_irq,
    output wire        counter1_carry_n
);
    reg  [15:0] count_reg [0:2];
    reg  [15:0] reload_reg [0:2];
    reg  [2:0]  armed_reg;
    reg  [2:0]  out_reg;
    wire [2:0]  gate;
    wire [2:0]  clk_in;
    wire        carry1;
    assign gate = {counter12_gate, counter12_gate, counter0_gate};
    assign carry1 = tick && gate[1] && armed_reg[1] && (count_reg[1] == 16'h0001);
    // R12 counter two clock
    assign clk_in = {carry1, tick, tick};
    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_cnt
            localparam [1:0] sel_idx = i;
            always @(posedge clk) begin
                if (!rst_n) begin
                    count_reg[i]  <= `PMBC_ZERO16;
                    reload_reg[i] <= `PMBC_ZERO16;
                    armed_reg[i]  <= 1'b0;
                    out_reg[i]    <= 1'b0;
                end else begin
                    // R14 select gates strobes
                    if (!timer_select_n && !io_write_n && sel == sel_idx)
                        reload_reg[i] <= wdata;
                    if (!gate[i])
                        armed_reg[i] <= 1'b0;
                    // R11 gate then load
                    else if (clk_in[i]) begin
                        if (!armed_reg[i]) begin
                            count_reg[i] <= reload_reg[i];
                            armed_reg[i] <= 1'b1;
                            out_reg[i]   <= 1'b0;
                        end else if (count_reg[i] == 16'h0001) begin
                            count_reg[i] <= reload_reg[i];
                            out_reg[i]   <= 1'b1;
                        end else begin
                            count_reg[i] <= count_reg[i] - 16'h0001;
                        end
                    end
                end
            end
        end
    endgenerate
    // R15 counter zero output
    assign timer_irq = out_reg[0];
    assign counter1_carry_n = ~carry1;
endmodule // pmbc_timer
`default_nettype wire

/* hw/pmbc_ctrl.v */
// Purpose: Processor memory bus controller: cycle sequencing, address and data paths, timer glue.
// Assumes: All inputs synchronous to CLOCK; one state per half cycle.
// Notes: Every top output is a flip-flop; outputs lag their cause by one clock, IRQ by two, SYNC_RESET_N by three.
`timescale 1ns/100ps
`default_nettype none
`include "pmbc_map.vh"
module pmbc_ctrl #(
    parameter TICK_CYCLES = `PMBC_TICK_CYCLES
) (
    // Clock and reset
    input  wire        CLOCK,
    input  wire        RESET_N,
    // Reset sources
    input  wire        HARD_RESET_N,
    input  wire        BOARD_SOFT_RESET_N,
    input  wire        DEBUGGER_RESET_N,
    // Decoder requests
    input  wire        MEM_REF_REQ,
    input  wire        MAP_REF_REQ,
    input  wire        IO_REF_REQ,
    input  wire        PRED_MEM,
    input  wire        SET_IRQ,
    input  wire        CLEAR_IRQ_N,
    input  wire        IRQ_ENABLE,
    input  wire        INT_STATUS_READ_N,
    input  wire        EXT_IRQ,
    // Halt and bus
    input  wire        HALT_REQUEST_N,
    input  wire        BUS_READY,
    // Data paths
    input  wire [23:0] X_ADDR,
    input  wire [15:0] Y_BUS,
    input  wire [15:0] BUS_DATA_IN,
    // Cycle state
    output reg         SYSCLK_ENABLE,
    output reg         CYCLE1_FIRST_HALF,
    output reg         RUNNING_FLAG,
    output reg         BUS_IDLE,
    output reg         BUS_MEM_REQUEST,
    output reg         BUS_ADDR_LATCH_EN,
    output reg         SYNC_RESET_N,
    output reg         FIRST_INSTR_TRAP_N,
    output reg         IRQ,
    // Address path
    output reg  [15:0] BUS_ADDR_LOW,
    output reg  [6:0]  BUS_ADDR_HIGH,
    output reg         MEM_ADDR_HIGH_EN_N,
    output reg         MAP_ADDR_HIGH_EN_N,
    output reg         MEM_ADDR_LOW_EN_N,
    output reg         MAP_ADDR_LOW_EN_N,
    // Data path
    output reg  [15:0] BUS_DATA_OUT,
    output reg         BUS_DATA_OE,
    output reg         READ_DATA_ENABLE_N,
    output reg  [15:0] X_BUS_OUT,
    output reg         X_BUS_OE,
    // Timer glue
    output reg         TIMER_SELECT_N,
    output reg         COUNTER0_GATE,
    output reg         COUNTER12_GATE,
    output reg         TIMER_IRQ
);
    localparam [9:0] S_CYCLE1_FIRST_HALF = 10'h001, S_C1SH = 10'h002, S_C2FH = 10'h004, S_C2SH = 10'h008;
    localparam [9:0] S_C3FH = 10'h010, S_C3SH = 10'h020, S_RC3FH = 10'h040, S_RC3SH = 10'h080;
    localparam [9:0] S_STOP = 10'h100, S_BOOT = 10'h200;

    reg  [9:0]  state_reg;
    reg  [9:0]  state_next;
    reg  [1:0]  rst_sync_reg;
    reg         booted_reg;
    reg         ref_reg, map_reg, write_reg;
    reg  [15:0] mar_low_reg, map_low_reg;
    reg  [6:0]  addr_high_reg;
    reg  [15:0] wd_reg;
    reg  [31:0] tick_cnt_reg;
    reg         tick_reg;
    reg         irq_reg;
    wire        any_req;
    wire        halt;
    wire        timer_out;
    wire        carry_n;
    wire        io_write_n;
    wire [3:0]  dec;
    wire        rst;

    assign any_req = MEM_REF_REQ | MAP_REF_REQ | IO_REF_REQ;
    assign halt = ~HALT_REQUEST_N;
    assign rst = ~RESET_N | ~SYNC_RESET_N;
    assign dec = {X_ADDR[23], X_ADDR[21], X_ADDR[20], X_ADDR[19]};
    assign io_write_n = ~(ref_reg & ~map_reg & write_reg & IO_REF_REQ);

    // R18 merged synchronised reset
    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            rst_sync_reg <= 2'h0;
            SYNC_RESET_N <= 1'b0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], HARD_RESET_N & BOARD_SOFT_RESET_N & DEBUGGER_RESET_N};
            SYNC_RESET_N <= rst_sync_reg[1];
        end
    end

    always @* begin
        state_next = state_reg;
        case (state_reg)
            S_BOOT:  state_next = halt ? S_BOOT : S_CYCLE1_FIRST_HALF;
            S_CYCLE1_FIRST_HALF:  state_next = S_C1SH;
            S_C1SH:  state_next = S_C2FH;
            S_C2FH:  state_next = S_C2SH;
            // R02 halt at cycle 2/3 boundary
            S_C2SH:  state_next = (halt && !ref_reg) ? S_STOP :
                                  (ref_reg && !write_reg) ? S_RC3FH : S_C3FH;
            // R26 resume at cycle 3
            S_STOP:  state_next = halt ? S_STOP : S_C3FH;
            S_C3FH:  state_next = S_C3SH;
            S_C3SH:  state_next = (ref_reg && write_reg && !BUS_READY) ? S_C3SH : S_CYCLE1_FIRST_HALF;
            // R25 read waits for ready
            S_RC3FH: state_next = BUS_READY ? S_RC3SH : S_RC3FH;
            S_RC3SH: state_next = S_CYCLE1_FIRST_HALF;
            default: state_next = S_CYCLE1_FIRST_HALF;
        endcase
    end

    always @(posedge CLOCK) begin
        if (rst) begin
            state_reg     <= S_BOOT;
            booted_reg    <= 1'b0;
            ref_reg       <= 1'b0;
            map_reg       <= 1'b0;
            write_reg     <= 1'b0;
            mar_low_reg   <= `PMBC_ZERO16;
            map_low_reg   <= `PMBC_ZERO16;
            addr_high_reg <= 7'h00;
            wd_reg        <= `PMBC_ZERO16;
        end else begin
            state_reg <= state_next;
            if (state_reg == S_BOOT && !halt)
                booted_reg <= 1'b1;
            if (state_reg == S_CYCLE1_FIRST_HALF) begin
                ref_reg   <= any_req;
                map_reg   <= MAP_REF_REQ;
                write_reg <= MEM_REF_REQ & ~PRED_MEM;
                // R06 high address capture
                if (any_req)
                    addr_high_reg <= X_ADDR[23:17];
            end
            // R05 low address to both
            if (state_reg == S_C1SH && ref_reg) begin
                mar_low_reg <= X_ADDR[15:0];
                map_low_reg <= X_ADDR[15:0];
            end
            // R08 write data capture
            if (state_reg == S_C2SH && ref_reg && write_reg)
                wd_reg <= Y_BUS;
            if (state_reg == S_C3SH || state_reg == S_RC3SH)
                ref_reg <= 1'b0;
        end
    end

    // R13 16 ms primary tick
    always @(posedge CLOCK) begin
        if (rst) begin
            tick_cnt_reg <= 32'h0000_0000;
            tick_reg     <= 1'b0;
        end else if (tick_cnt_reg == TICK_CYCLES - 1) begin
            tick_cnt_reg <= 32'h0000_0000;
            tick_reg     <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
            tick_reg     <= 1'b0;
        end
    end

    always @(posedge CLOCK) begin
        if (rst) begin
            SYSCLK_ENABLE      <= 1'b0;
            CYCLE1_FIRST_HALF  <= 1'b0;
            RUNNING_FLAG       <= 1'b0;
            // R27 reset asserts idle
            BUS_IDLE           <= 1'b1;
            BUS_MEM_REQUEST    <= 1'b0;
            BUS_ADDR_LATCH_EN  <= 1'b0;
            FIRST_INSTR_TRAP_N <= 1'b1;
            irq_reg            <= 1'b0;
            IRQ                <= 1'b0;
            BUS_ADDR_LOW       <= `PMBC_ZERO16;
            BUS_ADDR_HIGH      <= 7'h00;
            MEM_ADDR_HIGH_EN_N <= 1'b1;
            MAP_ADDR_HIGH_EN_N <= 1'b1;
            MEM_ADDR_LOW_EN_N  <= 1'b1;
            MAP_ADDR_LOW_EN_N  <= 1'b1;
            BUS_DATA_OUT       <= `PMBC_ZERO16;
            BUS_DATA_OE        <= 1'b0;
            READ_DATA_ENABLE_N <= 1'b1;
            X_BUS_OUT          <= `PMBC_ZERO16;
            X_BUS_OE           <= 1'b0;
            TIMER_SELECT_N     <= 1'b1;
            COUNTER0_GATE      <= 1'b0;
            COUNTER12_GATE     <= 1'b0;
            TIMER_IRQ          <= 1'b0;
        end else begin
            // R23 enable in second halves
            SYSCLK_ENABLE     <= state_next == S_C1SH || state_next == S_C2SH ||
                                 state_next == S_C3SH || state_next == S_RC3SH;
            CYCLE1_FIRST_HALF <= state_next == S_CYCLE1_FIRST_HALF;
            RUNNING_FLAG      <= state_next != S_BOOT && state_next != S_STOP;
            // R03 idle when no reference
            BUS_IDLE          <= ~(ref_reg | (state_reg == S_CYCLE1_FIRST_HALF && any_req));
            // R24 cycle 1 latch enable
            BUS_ADDR_LATCH_EN <= state_reg == S_CYCLE1_FIRST_HALF && any_req;
            // R20 request on memory or map
            BUS_MEM_REQUEST   <= state_reg == S_CYCLE1_FIRST_HALF && (MEM_REF_REQ | MAP_REF_REQ);
            // R19 trap after boot
            FIRST_INSTR_TRAP_N <= ~(state_reg == S_BOOT && !halt && !booted_reg);
            // R22 set wins over clear
            if (SET_IRQ && IRQ_ENABLE)
                irq_reg <= 1'b1;
            else if (!CLEAR_IRQ_N)
                irq_reg <= 1'b0;
            IRQ <= irq_reg;
            // R07 single address source
            MEM_ADDR_HIGH_EN_N <= ~(ref_reg & ~map_reg);
            MAP_ADDR_HIGH_EN_N <= ~(ref_reg & map_reg);
            MEM_ADDR_LOW_EN_N  <= ~(ref_reg & ~map_reg);
            MAP_ADDR_LOW_EN_N  <= ~(ref_reg & map_reg);
            BUS_ADDR_LOW       <= map_reg ? map_low_reg : mar_low_reg;
            BUS_ADDR_HIGH      <= addr_high_reg;
            // R09 write data drive
            BUS_DATA_OE        <= ref_reg & write_reg & (state_reg == S_C3FH || state_reg == S_C3SH);
            BUS_DATA_OUT       <= wd_reg;
            // R04 read enable end cycle 2
            READ_DATA_ENABLE_N <= ~(state_reg == S_C2SH && ref_reg && PRED_MEM);
            // R01 status onto X 13..15
            X_BUS_OE  <= ~INT_STATUS_READ_N;
            X_BUS_OUT <= INT_STATUS_READ_N ? BUS_DATA_IN :
                         {timer_out, EXT_IRQ, irq_reg, 13'h0000};
            // R16 timer chip select
            TIMER_SELECT_N <= ~(IO_REF_REQ && dec[3:1] == `PMBC_DEC_CS);
            // R17 gate decode
            if (IO_REF_REQ && dec == `PMBC_DEC_CLR0)
                COUNTER0_GATE <= 1'b0;
            else if (IO_REF_REQ && dec == `PMBC_DEC_SET0)
                COUNTER0_GATE <= 1'b1;
            if (IO_REF_REQ && dec == `PMBC_DEC_SET12)
                COUNTER12_GATE <= 1'b1;
            TIMER_IRQ <= timer_out;
        end
    end

    // R10 counter select bits
    pmbc_timer u_timer (
        .clk              (CLOCK),
        .rst_n            (~rst),
        .timer_select_n   (TIMER_SELECT_N),
        .io_write_n       (io_write_n),
        .sel              ({X_ADDR[`PMBC_A_SEL1], X_ADDR[`PMBC_A_SEL0]}),
        .wdata            (Y_BUS),
        .tick             (tick_reg),
        .counter0_gate    (COUNTER0_GATE),
        .counter12_gate   (COUNTER12_GATE),
        .timer_irq        (timer_out),
        .counter1_carry_n (carry_n)
    );
endmodule // pmbc_ctrl
`default_nettype wire

/* verif/pmbc_ctrl_monitor.sv */
// Purpose: Port-level checker for the memory bus controller.
// Assumes: Every output is registered on CLOCK.
// Notes: Checks hold off while either reset is active, except a_reset_clear, which checks during reset.
`timescale 1ns/100ps
`default_nettype none
module pmbc_ctrl_monitor (
    // Clock and resets
    input wire logic        CLOCK, RESET_N, SYNC_RESET_N,
    // Requests
    input wire logic        MEM_REF_REQ, MAP_REF_REQ, SET_IRQ, IRQ_ENABLE, CLEAR_IRQ_N,
    input wire logic        INT_STATUS_READ_N, EXT_IRQ,
    // Observed outputs
    input wire logic        CYCLE1_FIRST_HALF, RUNNING_FLAG, BUS_IDLE, BUS_MEM_REQUEST, BUS_ADDR_LATCH_EN,
    input wire logic        FIRST_INSTR_TRAP_N, IRQ, MEM_ADDR_HIGH_EN_N, MAP_ADDR_HIGH_EN_N,
    input wire logic        MEM_ADDR_LOW_EN_N, MAP_ADDR_LOW_EN_N, BUS_DATA_OE, READ_DATA_ENABLE_N,
    input wire logic        X_BUS_OE, COUNTER0_GATE, COUNTER12_GATE,
    input wire logic [15:0] X_BUS_OUT
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESET_N || !SYNC_RESET_N);
    a_status_bit: assert property (!INT_STATUS_READ_N |=> X_BUS_OE && X_BUS_OUT[14] == $past(EXT_IRQ))
        else $error("status read did not show external interrupt");
    a_halt_idle: assert property ($fell(RUNNING_FLAG) |-> BUS_IDLE)
        else $error("stopped while bus busy");
    a_drive_busy: assert property (BUS_DATA_OE |-> !BUS_IDLE)
        else $error("write data driven while idle");
    a_read_busy: assert property (!READ_DATA_ENABLE_N |-> !BUS_IDLE)
        else $error("read data enabled while idle");
    a_addr_single: assert property (!(!MEM_ADDR_HIGH_EN_N && !MAP_ADDR_HIGH_EN_N)
        && !(!MEM_ADDR_LOW_EN_N && !MAP_ADDR_LOW_EN_N)) else $error("two address sources enabled");
    a_trap_pulse: assert property (!FIRST_INSTR_TRAP_N |=> FIRST_INSTR_TRAP_N)
        else $error("initial trap longer than one cycle");
    a_req_cause: assert property ($rose(BUS_MEM_REQUEST) |-> $past(CYCLE1_FIRST_HALF)
        && ($past(MEM_REF_REQ) || $past(MAP_REF_REQ))) else $error("memory request without reference");
    a_irq_set: assert property (SET_IRQ && IRQ_ENABLE |=> ##1 IRQ)
        else $error("interrupt not set");
    a_irq_clear: assert property (!CLEAR_IRQ_N && !(SET_IRQ && IRQ_ENABLE) ##1 !(SET_IRQ && IRQ_ENABLE) |=> !IRQ)
        else $error("interrupt not cleared");
    a_latch_cycle1: assert property (BUS_ADDR_LATCH_EN |-> $past(CYCLE1_FIRST_HALF))
        else $error("latch enable outside cycle one");
    a_reset_clear: assert property (disable iff (1'b0) !RESET_N |=> !COUNTER0_GATE
        && !COUNTER12_GATE && !IRQ && BUS_IDLE) else $error("reset left state behind");
endmodule // pmbc_ctrl_monitor
bind pmbc_ctrl pmbc_ctrl_monitor pmbc_ctrl_monitor_inst (.*);
`default_nettype wire

/* verif/pmbc_mem_model.sv */
// Purpose: Behavioural memory controller answering with ready.
// Assumes: One reference outstanding at a time.
// Notes: Delay input chooses a prompt or a slow answer.
`timescale 1ns/100ps
`default_nettype none
module pmbc_mem_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Bus side
    input  wire logic       latch,
    input  wire logic       cycle1_first_half,
    input  wire logic [3:0] delay,
    output var  logic       ready
);
    logic [3:0] wait_reg;
    logic       busy_reg;
    always @(posedge clk) begin
        if (!rst_n) begin
            busy_reg <= 1'b0;
            wait_reg <= 4'h0;
            ready    <= 1'b0;
        end else if (latch) begin
            busy_reg <= 1'b1;
            wait_reg <= delay;
            ready    <= 1'b0;
        end else if (busy_reg && wait_reg != 4'h0) begin
            wait_reg <= wait_reg - 4'h1;
        end else if (busy_reg) begin
            busy_reg <= 1'b0;
            ready    <= 1'b1;
        end else if (cycle1_first_half) begin
            ready <= 1'b0;
        end
    end
endmodule // pmbc_mem_model
`default_nettype wire

/* verif/test_pmbc_ctrl.sv */
// Purpose: Self-checking bench for the memory bus controller.
// Assumes: Tick shortened to 20 cycles.
// Notes: Table rows cover references; interrupt, halt and reset follow.
`timescale 1ns/100ps
`default_nettype none
module test_pmbc_ctrl;
    typedef struct packed {logic [3:0] k; logic [23:0] a; logic [15:0] d; logic sel, g0, g12;} pmbc_row_t;
    logic clock = 1'b0, reset_n = 1'b0, hard_n = 1'b1, soft_n = 1'b1, dbg_n = 1'b1, ready;
    logic mem_req = 1'b0, map_req = 1'b0, io_req = 1'b0, pred = 1'b0, set_irq = 1'b0, clr_n = 1'b1;
    logic irq_en = 1'b0, stat_n = 1'b1, ext_irq = 1'b0, halt_n = 1'b0;
    logic [23:0] x_addr = 24'h00_0000;
    logic [15:0] y_bus = 16'h0000;
    logic [3:0]  delay = 4'h0;
    wire sys_en, cycle1_first_half, running, idle, mreq, ale, sync_n, trap_n, irq, mah_n, pah_n, mal_n, pal_n;
    wire data_oe, rd_n, xoe, tsel_n, gate0, gate12, tirq;
    wire [15:0] addr_lo, data_out, xout;
    wire [6:0]  addr_hi;
    int err_total = 0, compares = 0, cycles = 0, n, cnt;
    pmbc_row_t rows [9] = '{
        '{4'h8, 24'h24_68AC, 16'hBEEF, 1'b0, 1'b0, 1'b0}, '{4'h9, 24'h7F_FFFF, 16'h0000, 1'b0, 1'b0, 1'b0},
        '{4'h5, 24'h00_0001, 16'h0000, 1'b0, 1'b0, 1'b0}, '{4'h4, 24'hFE_DCBA, 16'h1234, 1'b0, 1'b0, 1'b0},
        '{4'h2, 24'h86_0000, 16'h0034, 1'b1, 1'b0, 1'b0}, '{4'h2, 24'h80_0000, 16'h0003, 1'b1, 1'b0, 1'b0},
        '{4'h2, 24'h98_0000, 16'h0000, 1'b0, 1'b1, 1'b0}, '{4'h2, 24'hA8_0000, 16'h0000, 1'b0, 1'b1, 1'b1},
        '{4'h2, 24'h90_0000, 16'h0000, 1'b0, 1'b0, 1'b1}};
    pmbc_ctrl #(.TICK_CYCLES(20)) pmbc_ctrl_inst (.CLOCK(clock), .RESET_N(reset_n), .HARD_RESET_N(hard_n),
        .BOARD_SOFT_RESET_N(soft_n), .DEBUGGER_RESET_N(dbg_n), .MEM_REF_REQ(mem_req), .MAP_REF_REQ(map_req),
        .IO_REF_REQ(io_req), .PRED_MEM(pred), .SET_IRQ(set_irq), .CLEAR_IRQ_N(clr_n), .IRQ_ENABLE(irq_en),
        .INT_STATUS_READ_N(stat_n), .EXT_IRQ(ext_irq), .HALT_REQUEST_N(halt_n), .BUS_READY(ready),
        .X_ADDR(x_addr), .Y_BUS(y_bus), .BUS_DATA_IN(16'hA5A5), .SYSCLK_ENABLE(sys_en),
        .CYCLE1_FIRST_HALF(cycle1_first_half), .RUNNING_FLAG(running), .BUS_IDLE(idle), .BUS_MEM_REQUEST(mreq),
        .BUS_ADDR_LATCH_EN(ale), .SYNC_RESET_N(sync_n), .FIRST_INSTR_TRAP_N(trap_n), .IRQ(irq),
        .BUS_ADDR_LOW(addr_lo), .BUS_ADDR_HIGH(addr_hi), .MEM_ADDR_HIGH_EN_N(mah_n), .MAP_ADDR_HIGH_EN_N(pah_n),
        .MEM_ADDR_LOW_EN_N(mal_n), .MAP_ADDR_LOW_EN_N(pal_n), .BUS_DATA_OUT(data_out), .BUS_DATA_OE(data_oe),
        .READ_DATA_ENABLE_N(rd_n), .X_BUS_OUT(xout), .X_BUS_OE(xoe), .TIMER_SELECT_N(tsel_n),
        .COUNTER0_GATE(gate0), .COUNTER12_GATE(gate12), .TIMER_IRQ(tirq));
    pmbc_mem_model pmbc_mem_model_inst (.clk(clock), .rst_n(reset_n), .latch(ale), .cycle1_first_half(cycle1_first_half),
        .delay(delay), .ready(ready));
    always #4 clock = ~clock;
    task automatic print_verdict();
        if (err_total == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic boot();
        logic t;
        t = 1'b0;
        @(posedge clock) halt_n <= 1'b0;
        repeat (8) @(posedge clock);
        halt_n <= 1'b1;
        repeat (60) begin
            @(negedge clock);
            if (trap_n === 1'b0) t = 1'b1;
        end
        check(t, 1'b1);
        check(running, 1'b1);
    endtask
    task automatic status(input logic [1:0] exp);
        @(posedge clock) stat_n <= 1'b0;
        @(posedge clock) stat_n <= 1'b1;
        @(negedge clock) check(xoe, 1'b1);
        check(xout[14:13], exp);
    endtask
    task automatic do_ref(input pmbc_row_t r);
        logic sr, srd, smh, sph, ssel, dropped;
        logic [15:0] wd;
        {sr, srd, smh, sph, ssel, dropped, wd} = '0;
        @(posedge clock) {mem_req, map_req, io_req, pred} <= r.k;
        x_addr <= r.a;
        y_bus <= r.d;
        for (n = 0; n < 80 && !(dropped && cycle1_first_half === 1'b1); n++) begin
            @(negedge clock);
            {sr, srd, smh, sph, ssel} = {sr | mreq, srd | !rd_n, smh | !mah_n, sph | !pah_n, ssel | !tsel_n};
            if (data_oe === 1'b1) wd = data_out;
            if (ale === 1'b1 && !dropped) begin
                @(posedge clock) {mem_req, map_req, io_req} <= 3'h0;
                dropped = 1'b1;
            end
        end
        check(sr, r.k[3] | r.k[2]);
        if (r.k[3] | r.k[2]) check(srd, r.k[0]);
        check({smh, sph}, {r.k[3] | r.k[1], r.k[2]});
        check(addr_hi, r.a[23:17]);
        check(addr_lo, r.a[15:0]);
        if (r.k[3] & !r.k[0]) check(wd, r.d);
        check({ssel, gate0, gate12}, {r.sel, r.g0, r.g12});
    endtask
    initial begin
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        boot();
        check({idle, gate0, gate12}, 3'h4);
        foreach (rows[i]) begin
            delay <= (i % 2) ? 4'h6 : 4'h0;
            do_ref(rows[i]);
        end
        @(posedge clock) set_irq <= 1'b1;
        @(posedge clock) set_irq <= 1'b0;
        @(negedge clock) check(irq, 1'b0);
        @(posedge clock) {irq_en, set_irq, ext_irq} <= 3'h7;
        @(posedge clock) set_irq <= 1'b0;
        @(posedge clock);
        @(negedge clock) check(irq, 1'b1);
        status(2'h3);
        @(posedge clock) {clr_n, ext_irq} <= 2'h0;
        @(posedge clock) clr_n <= 1'b1;
        @(posedge clock);
        @(negedge clock) check(irq, 1'b0);
        status(2'h0);
        @(posedge clock) halt_n <= 1'b0;
        for (n = 0; n < 30 && running !== 1'b0; n++) @(negedge clock);
        check({running, idle}, 2'h1);
        cnt = 0;
        repeat (8) @(negedge clock) cnt += (sys_en === 1'b1);
        check(cnt, 0);
        @(posedge clock) halt_n <= 1'b1;
        for (n = 0; n < 30 && running !== 1'b1; n++) @(negedge clock);
        repeat (8) @(negedge clock) cnt += (sys_en === 1'b1);
        check(cnt > 0, 1'b1);
        @(posedge clock) {irq_en, set_irq} <= 2'h3;
        @(posedge clock) {set_irq, dbg_n, halt_n} <= 3'h0;
        @(posedge clock) dbg_n <= 1'b1;
        for (n = 0; n < 10 && sync_n !== 1'b0; n++) @(negedge clock);
        check(sync_n, 1'b0);
        @(negedge clock) check({gate0, gate12, irq, idle}, 4'h1);
        boot();
        do_ref(rows[0]);
        print_verdict();
    end
endmodule // test_pmbc_ctrl
`default_nettype wire
